// ==== inc/dacuc_params.svh ====
// Constants for the converter input update control block
`ifndef DACUC_PARAMS_SVH
`define DACUC_PARAMS_SVH
`define DACUC_ADDR_CONTROL   2'h0
`define DACUC_ADDR_HIGH      2'h1
`define DACUC_ADDR_LOW       2'h2
`define DACUC_BIT_ATE        7
`define DACUC_TS_HI          6
`define DACUC_TS_LO          4
`define DACUC_BIT_LA         2
`define DACUC_BIT_OE         1
`define DACUC_BIT_EN         0
`define DACUC_CTRL_RESET     8'h00
`define DACUC_BYTE_RESET     8'h00
`define DACUC_VALUE_RESET    10'h000
`define DACUC_CTRL_MASK      8'hf7
`define DACUC_RIGHT_HI_MASK  8'h03
`define DACUC_LEFT_LO_MASK   8'hc0
`define DACUC_CONV_CYCLES    4'h3
`define DACUC_CNT_ZERO       4'h0
`define DACUC_CNT_ONE        4'h1
`define DACUC_NUM_SOURCES    8
`endif

// ==== inc/dacuc_pkg.sv ====
// Types shared by the converter input update control block
package dacuc_pkg;
    typedef struct packed {
        logic       auto_trigger_enable;
        logic [2:0] trigger_select;
        // Bit 3 has no function and is always stored as zero
        logic       spare_zero;
        logic       left_adjust;
        logic       output_pin_enable;
        logic       converter_enable;
    } dacuc_ctrl_type;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } dacuc_bus_type;

    typedef enum logic [1:0] {
        DACUC_IDLE = 2'b01,
        DACUC_BUSY = 2'b10
    } dacuc_state_type;
endpackage : dacuc_pkg

// ==== core/dacuc_trigger_sel.sv ====
// Trigger source selection and rising edge detection
`timescale 1ns/1ps
`include "dacuc_params.svh"
module dacuc_trigger_sel
    import dacuc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic [7:0] event_flags,
    input  wire logic [2:0] trigger_select,
    output logic            trigger_pulse
);
    logic [7:0] flag_prev_q;
    logic [7:0] flag_rise;
    logic       rise_sel;

    // Edge of flag level, so interrupt enable plays no part
    genvar i;
    generate
        for (i = 0; i < `DACUC_NUM_SOURCES; i = i + 1)
        begin : g_edge
            assign flag_rise[i] = event_flags[i] & ~flag_prev_q[i];
        end
    endgenerate

    assign rise_sel = flag_rise[trigger_select];

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            flag_prev_q   <= 8'h00;
            trigger_pulse <= 1'b0;
        end
        else
        begin
            flag_prev_q   <= event_flags;
            trigger_pulse <= rise_sel;
        end
    end
endmodule : dacuc_trigger_sel

// ==== core/dacuc_value_fmt.sv ====
// Assembly of the 10-bit value from the byte pair
`timescale 1ns/1ps
`include "dacuc_params.svh"
module dacuc_value_fmt
    import dacuc_pkg::*;
(
    input  wire logic [7:0] high_byte,
    input  wire logic [7:0] low_byte,
    input  wire logic       left_adjust,
    output logic [9:0]      value
);
    logic [9:0] left_value;
    logic [9:0] right_value;

    assign left_value  = {high_byte, low_byte[7:6]};
    assign right_value = {high_byte[1:0], low_byte};
    assign value       = left_adjust ? left_value : right_value;
endmodule : dacuc_value_fmt

// ==== core/dacuc_top.sv ====
// Converter input update control: registers, shadow value, trigger logic
`timescale 1ns/1ps
`include "dacuc_params.svh"
module dacuc_top
    import dacuc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic [1:0] bus_addr,
    input  wire logic [7:0] bus_wdata,
    input  wire logic       bus_wr,
    input  wire logic       bus_rd,
    output logic      [7:0] bus_rdata,
    input  wire logic [7:0] event_flags,
    output logic      [9:0] converter_value,
    output logic            converter_enable,
    output logic            analog_output_pin,
    output logic            conversion_busy
);
    import dacuc_pkg::*;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    dacuc_bus_type  bus;
    dacuc_ctrl_type ctrl_q;
    logic [7:0]     high_q;
    logic [7:0]     low_q;
    logic           low_pending_q;
    logic [9:0]     shadow_q;
    logic [3:0]     conv_cnt_q;
    dacuc_state_type state_q;
    dacuc_state_type state_d;

    assign bus = '{addr: bus_addr, wdata: bus_wdata,
                   wr: bus_wr, rd: bus_rd};

    function automatic logic hit(input logic [1:0] a, input logic [1:0] r);
        hit = (a == r);
    endfunction : hit

    logic wr_ctrl;
    logic wr_high;
    logic wr_low;
    assign wr_ctrl = bus.wr & hit(bus.addr, `DACUC_ADDR_CONTROL);
    assign wr_high = bus.wr & hit(bus.addr, `DACUC_ADDR_HIGH);
    assign wr_low  = bus.wr & hit(bus.addr, `DACUC_ADDR_LOW);

    logic [7:0] ctrl_byte;
    assign ctrl_byte = ctrl_q;

    // Unmapped address reads zero
    logic [7:0] rd_mux;
    assign rd_mux = hit(bus.addr, `DACUC_ADDR_CONTROL) ? ctrl_byte :
                    hit(bus.addr, `DACUC_ADDR_HIGH)    ? high_q :
                    hit(bus.addr, `DACUC_ADDR_LOW)     ? low_q : 8'h00;

    // Stored bytes masked to the layout active at write time
    logic [7:0] high_wmask;
    logic [7:0] low_wmask;
    assign high_wmask = ctrl_q.left_adjust ? 8'hff
                                           : `DACUC_RIGHT_HI_MASK;
    assign low_wmask  = ctrl_q.left_adjust ? `DACUC_LEFT_LO_MASK
                                           : 8'hff;

    // ------------------------------------------------------------
    // Trigger and value assembly
    // ------------------------------------------------------------
    logic       trig_pulse;
    logic [9:0] fmt_value;

    dacuc_trigger_sel u_trig (
        .sys_clk        (sys_clk),
        .reset          (reset),
        .event_flags    (event_flags),
        .trigger_select (ctrl_q.trigger_select),
        .trigger_pulse  (trig_pulse)
    );

    // Layout taken from new control only matters at a load
    dacuc_value_fmt u_fmt (
        .high_byte   (wr_high ? (bus.wdata & high_wmask) : high_q),
        .low_byte    (low_q),
        .left_adjust (ctrl_q.left_adjust),
        .value       (fmt_value)
    );

    // ------------------------------------------------------------
    // Update decision
    // ------------------------------------------------------------
    logic manual_load;
    logic auto_load;
    logic load;
    logic idle;
    assign idle        = (state_q == DACUC_IDLE);
    assign manual_load = ~ctrl_q.auto_trigger_enable & wr_high;
    // Select field used only in auto mode; pending low write blocks
    assign auto_load   = ctrl_q.auto_trigger_enable & trig_pulse
                         & ~low_pending_q & ~wr_low & idle;
    assign load        = manual_load | auto_load;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            DACUC_IDLE:
                if (auto_load)
                    state_d = DACUC_BUSY;
            DACUC_BUSY:
                if (conv_cnt_q == `DACUC_CNT_ONE)
                    state_d = DACUC_IDLE;
            default:
                state_d = DACUC_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            ctrl_q <= `DACUC_CTRL_RESET;
            high_q <= `DACUC_BYTE_RESET;
            low_q  <= `DACUC_BYTE_RESET;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= bus.wdata & `DACUC_CTRL_MASK;
            if (wr_high)
                high_q <= bus.wdata & high_wmask;
            if (wr_low)
                low_q <= bus.wdata & low_wmask;
        end
    end

    // Low write arms the block; the high write releases it
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            low_pending_q <= 1'b0;
        else if (wr_low)
            low_pending_q <= 1'b1;
        else if (wr_high)
            low_pending_q <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            shadow_q <= `DACUC_VALUE_RESET;
        else if (load)
            shadow_q <= fmt_value;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_q    <= DACUC_IDLE;
            conv_cnt_q <= `DACUC_CNT_ZERO;
        end
        else
        begin
            state_q <= state_d;
            if (auto_load)
                conv_cnt_q <= `DACUC_CONV_CYCLES;
            else if (conv_cnt_q != `DACUC_CNT_ZERO)
                conv_cnt_q <= conv_cnt_q - `DACUC_CNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            bus_rdata         <= 8'h00;
            converter_value   <= `DACUC_VALUE_RESET;
            converter_enable  <= 1'b0;
            analog_output_pin <= 1'b0;
            conversion_busy   <= 1'b0;
        end
        else
        begin
            bus_rdata         <= bus.rd ? rd_mux : 8'h00;
            converter_value   <= shadow_q;
            converter_enable  <= ctrl_q.converter_enable;
            analog_output_pin <= ctrl_q.converter_enable
                                 & ctrl_q.output_pin_enable;
            conversion_busy   <= (state_d == DACUC_BUSY);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_manual_load: assert property (@(posedge sys_clk) disable iff (reset)
        manual_load |=> shadow_q == $past(fmt_value))
        else $error("high write did not load shadow");
    a_auto_block: assert property (@(posedge sys_clk) disable iff (reset)
        ctrl_q.auto_trigger_enable && !trig_pulse |=> $stable(shadow_q))
        else $error("shadow changed without trigger");
    a_low_blocks: assert property (@(posedge sys_clk) disable iff (reset)
        low_pending_q && !wr_high |-> !auto_load)
        else $error("update while low write pending");
    a_busy_ignore: assert property (@(posedge sys_clk) disable iff (reset)
        state_q == DACUC_BUSY |-> !auto_load)
        else $error("trigger taken during conversion");
    a_busy_len: assert property (@(posedge sys_clk) disable iff (reset)
        auto_load |=> (state_q == DACUC_BUSY)[*3] ##1 state_q == DACUC_IDLE)
        else $error("conversion length wrong");
    a_pin_route: assert property (@(posedge sys_clk) disable iff (reset)
        !ctrl_q.output_pin_enable |=> !analog_output_pin)
        else $error("pin driven while routing off");
    a_enable_out: assert property (@(posedge sys_clk) disable iff (reset)
        ##1 converter_enable == $past(ctrl_q.converter_enable))
        else $error("enable output mismatch");
    a_right_zero: assert property (@(posedge sys_clk) disable iff (reset)
        wr_high && !ctrl_q.left_adjust |=> high_q[7:2] == 6'h00)
        else $error("right layout upper bits not zero");
    a_left_value: assert property (@(posedge sys_clk) disable iff (reset)
        manual_load && ctrl_q.left_adjust |=> shadow_q[9:2] == $past(bus.wdata))
        else $error("left layout value wrong");
    // Select taken one cycle back, where the edge detector used it
    a_edge_trig: assert property (@(posedge sys_clk) disable iff (reset)
        trig_pulse |->
            $past(event_flags[ctrl_q.trigger_select])
            && !$past(event_flags[ctrl_q.trigger_select], 2)
            || $past(ctrl_q.trigger_select)
               != $past(ctrl_q.trigger_select, 2))
        else $error("trigger without rising edge");

    // ------------------------------------------------------------
    // Assertions: update decision
    // ------------------------------------------------------------
    a_manual_hold: assert property (@(posedge sys_clk) disable iff (reset)
        !ctrl_q.auto_trigger_enable && !wr_high |=> $stable(shadow_q))
        else $error("shadow moved in manual mode without high write");
    a_shadow_hold: assert property (@(posedge sys_clk) disable iff (reset)
        !wr_high && !trig_pulse |=> $stable(shadow_q))
        else $error("shadow moved without write or trigger");
    a_pend_set: assert property (@(posedge sys_clk) disable iff (reset)
        wr_low |=> low_pending_q)
        else $error("low write did not arm the block");
    a_pend_clear: assert property (@(posedge sys_clk) disable iff (reset)
        wr_high |=> !low_pending_q)
        else $error("high write did not release the block");
    a_auto_value: assert property (@(posedge sys_clk) disable iff (reset)
        auto_load |=> shadow_q == $past(fmt_value))
        else $error("trigger did not load shadow");
    a_right_value: assert property (@(posedge sys_clk) disable iff (reset)
        manual_load && !ctrl_q.left_adjust |=>
            shadow_q[9:8] == $past(bus.wdata[1:0]))
        else $error("right layout value wrong");
    a_cnt_idle: assert property (@(posedge sys_clk) disable iff (reset)
        state_q == DACUC_IDLE |-> conv_cnt_q == `DACUC_CNT_ZERO)
        else $error("conversion counter running while idle");

    // ------------------------------------------------------------
    // Assertions: registers and outputs
    // ------------------------------------------------------------
    a_ctrl_write: assert property (@(posedge sys_clk) disable iff (reset)
        wr_ctrl |=> ctrl_byte == ($past(bus.wdata) & `DACUC_CTRL_MASK))
        else $error("control write not stored");
    a_spare_zero: assert property (@(posedge sys_clk) disable iff (reset)
        ctrl_q.spare_zero == 1'b0)
        else $error("unused control bit set");
    a_left_low: assert property (@(posedge sys_clk) disable iff (reset)
        wr_low && ctrl_q.left_adjust |=> low_q[5:0] == 6'h00)
        else $error("left layout low bits not zero");
    a_value_out: assert property (@(posedge sys_clk) disable iff (reset)
        ##1 converter_value == $past(shadow_q))
        else $error("converter value out of step with shadow");
    a_rdata_idle: assert property (@(posedge sys_clk) disable iff (reset)
        !bus.rd |=> bus_rdata == 8'h00)
        else $error("read data shown without a read");
    a_pin_follow: assert property (@(posedge sys_clk) disable iff (reset)
        ##1 analog_output_pin
            == $past(ctrl_q.converter_enable && ctrl_q.output_pin_enable))
        else $error("pin routing does not follow control");
    a_busy_out: assert property (@(posedge sys_clk) disable iff (reset)
        conversion_busy == (state_q == DACUC_BUSY))
        else $error("busy output out of step with state");

    // ------------------------------------------------------------
    // Checker helpers
    // ------------------------------------------------------------
    // Busy run length, so the window is bounded without a long repeat
    logic [3:0] busy_run_q;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            busy_run_q <= `DACUC_CNT_ZERO;
        else if (state_q == DACUC_BUSY)
            busy_run_q <= busy_run_q + `DACUC_CNT_ONE;
        else
            busy_run_q <= `DACUC_CNT_ZERO;
    end

    a_busy_bound: assert property (@(posedge sys_clk) disable iff (reset)
        busy_run_q <= `DACUC_CONV_CYCLES)
        else $error("conversion window too long");

    // ------------------------------------------------------------
    // Cover
    // ------------------------------------------------------------
    c_manual: cover property (@(posedge sys_clk) manual_load);
    c_auto: cover property (@(posedge sys_clk) auto_load);
    c_busy_drop: cover property (@(posedge sys_clk)
        state_q == DACUC_BUSY && trig_pulse);
    c_pair: cover property (@(posedge sys_clk) wr_low ##[1:4] wr_high);
    c_left_load: cover property (@(posedge sys_clk)
        manual_load && ctrl_q.left_adjust);
endmodule : dacuc_top

// ==== verif/dacuc_tb_top.sv ====
// Self-checking bench for the converter input update control block
`timescale 1ns/1ps
`include "dacuc_params.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module dacuc_tb_top;
    import dacuc_pkg::*;
    logic       sys_clk = 1'b0;
    logic       reset = 1'b1;
    logic [1:0] bus_addr = 2'h0;
    logic [7:0] bus_wdata = 8'h00;
    logic       bus_wr = 1'b0;
    logic       bus_rd = 1'b0;
    logic [7:0] bus_rdata;
    logic [7:0] event_flags = 8'h00;
    logic [9:0] converter_value;
    logic       converter_enable;
    logic       analog_output_pin;
    logic       conversion_busy;
    int         fails = 0;
    int         comparisons = 0;
    int         busy_n;
    logic [7:0] hi, lo, d, r;
    logic [9:0] v = 10'h000;

    dacuc_top i_dut (.sys_clk(sys_clk), .reset(reset),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .event_flags(event_flags), .converter_value(converter_value),
        .converter_enable(converter_enable),
        .analog_output_pin(analog_output_pin),
        .conversion_busy(conversion_busy));

    always #12.5 sys_clk = ~sys_clk;

    // ---------------------------------------------------------------
    // Bus and expectation helpers
    // ---------------------------------------------------------------
    function automatic logic [9:0] expv(logic [7:0] h, logic [7:0] l,
                                        logic la);
        return la ? {h, l[7:6]} : {h[1:0], l};
    endfunction : expv

    task automatic wr(logic [1:0] a, logic [7:0] x);
        @(posedge sys_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= x;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask : wr

    task automatic rd(logic [1:0] a, output logic [7:0] x);
        @(posedge sys_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1 x = bus_rdata;
    endtask : rd

    // Shadow reaches the output one cycle after the load edge
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : settle

    // Flag held high, then cleared by software before the next event
    task automatic trig(int n);
        @(posedge sys_clk);
        event_flags[n] <= 1'b1;
        busy_n = 0;
        repeat (8)
        begin
            @(posedge sys_clk);
            #1 if (conversion_busy === 1'b1) busy_n++;
        end
        event_flags <= 8'h00;
        settle();
    endtask : trig

    task automatic final_report();
        if (fails == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    initial
    begin
        #(25.0 * 5000);
        fails++;
        final_report();
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h12ec));
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        for (int a = 0; a < 4; a++)
        begin
            rd(a[1:0], d);
            `CHK(d, 8'h00)
        end
        `CHK(converter_value, 10'h000)
        for (int i = 0; i < 4; i++)
        begin
            r = (i == 0) ? 8'hff : 8'($urandom);
            wr(`DACUC_ADDR_CONTROL, r);
            rd(`DACUC_ADDR_CONTROL, d);
            `CHK(d, r & `DACUC_CTRL_MASK)
            `CHK(converter_enable, r[0])
            `CHK(analog_output_pin, r[0] & r[1])
        end
        wr(`DACUC_ADDR_CONTROL, 8'h01);
        wr(2'h3, 8'hff);
        rd(2'h3, d);
        `CHK(d, 8'h00)
        // Manual mode, right layout, random values and edge values
        for (int i = 0; i < 6; i++)
        begin
            lo = (i == 0) ? 8'hff : 8'($urandom);
            hi = (i == 0) ? 8'hff : 8'($urandom);
            wr(`DACUC_ADDR_LOW, lo);
            settle();
            `CHK(converter_value, v)
            wr(`DACUC_ADDR_HIGH, hi);
            settle();
            v = expv(hi, lo, 1'b0);
            `CHK(converter_value, v)
            rd(`DACUC_ADDR_HIGH, d);
            `CHK(d, hi & `DACUC_RIGHT_HI_MASK)
        end
        event_flags <= 8'hff;
        settle();
        event_flags <= 8'h00;
        `CHK(converter_value, v)
        // Layout switch shows only at the next high write
        wr(`DACUC_ADDR_CONTROL, 8'h05);
        settle();
        `CHK(converter_value, v)
        hi = 8'($urandom);
        wr(`DACUC_ADDR_HIGH, hi);
        settle();
        v = expv(hi, lo, 1'b1);
        `CHK(converter_value, v)
        wr(`DACUC_ADDR_LOW, 8'hff);
        rd(`DACUC_ADDR_LOW, lo);
        `CHK(lo, `DACUC_LEFT_LO_MASK)
        // Auto mode: every trigger code, with a decoy source first
        for (int c = 0; c < 8; c++)
        begin
            wr(`DACUC_ADDR_CONTROL, {1'b1, 3'(c), 4'h1});
            hi = 8'($urandom);
            wr(`DACUC_ADDR_HIGH, hi);
            settle();
            `CHK(converter_value, v)
            trig((c + 1) % 8);
            `CHK(converter_value, v)
            trig(c);
            v = expv(hi, lo, 1'b0);
            `CHK(converter_value, v)
            `CHK(busy_n, 3)
        end
        // High-only use: each event updates again
        hi = 8'($urandom);
        wr(`DACUC_ADDR_HIGH, hi);
        trig(7);
        v = expv(hi, lo, 1'b0);
        `CHK(converter_value, v)
        // Low write pending blocks the trigger until high follows
        lo = 8'($urandom);
        wr(`DACUC_ADDR_LOW, lo);
        trig(7);
        `CHK(converter_value, v)
        hi = 8'($urandom);
        wr(`DACUC_ADDR_HIGH, hi);
        trig(7);
        v = expv(hi, lo, 1'b0);
        `CHK(converter_value, v)
        // Second edge inside the conversion window must be dropped
        hi = 8'($urandom);
        wr(`DACUC_ADDR_HIGH, hi);
        v = expv(hi, lo, 1'b0);
        @(posedge sys_clk);
        event_flags[7] <= 1'b1;
        @(posedge sys_clk);
        event_flags[7] <= 1'b0;
        @(posedge sys_clk);
        event_flags[7] <= 1'b1;
        bus_wr <= 1'b1;
        bus_addr <= `DACUC_ADDR_HIGH;
        bus_wdata <= ~hi;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
        repeat (8) @(posedge sys_clk);
        event_flags <= 8'h00;
        settle();
        `CHK(converter_value, v)
        final_report();
    end
endmodule : dacuc_tb_top
